/* File: src/fdr_pkg.sv */
/*
  Package for the floppy drive-input and rate-control port block: register indexes,
  field positions, reset values, rate codes, compatibility modes and carrier structs.
  Assumes a 32-bit APB with byte addresses equal to four times a register index.
*/
package fdr_pkg;

  // ==========================================================================
  // register map (index; byte address is four times the index)
  // ==========================================================================
  localparam int FDR_ADDR_W = 8;
  localparam logic [5:0] FDR_IDX_DATA_RATE = 6'h04;
  localparam logic [5:0] FDR_IDX_DIAG_RATE = 6'h07;
  localparam logic [5:0] FDR_IDX_DRV_STATUS = 6'h08;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int FDR_DIAG_CHG_BIT = 7;
  localparam int FDR_DIAG_DMA_BIT = 3;
  localparam int FDR_DIAG_PREC_BIT = 2;
  localparam int FDR_RATE_LSB = 0;
  localparam int FDR_PREC_WR_BIT = 2;

  // ==========================================================================
  // rate codes and reset values
  // ==========================================================================
  localparam logic [1:0] FDR_RATE_500K = 2'h0;
  localparam logic [1:0] FDR_RATE_300K = 2'h1;
  localparam logic [1:0] FDR_RATE_250K = 2'h2;
  localparam logic [1:0] FDR_RATE_1M = 2'h3;
  localparam logic [1:0] FDR_RATE_RST = 2'h2;
  localparam logic FDR_PREC_RST = 1'b0;
  localparam logic [7:0] FDR_OE_BASIC = 8'h80;
  localparam logic [7:0] FDR_OE_ALL = 8'hFF;
  localparam logic [3:0] FDR_SECOND_ONES = 4'hF;

  typedef enum logic [1:0] {
    FDR_BASIC_COMPAT_MODE,
    FDR_SECOND_COMPAT_MODE,
    FDR_THIRD_COMPAT_MODE
  } fdr_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [FDR_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } fdr_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fdr_apb_rsp_t;

  typedef struct packed {
    logic drive_fault;
    logic write_protect;
    logic drive_ready;
    logic track_zero;
    logic two_sided;
    logic head_address;
    logic unit_select_hi;
    logic unit_select_lo;
  } fdr_drv_stat_t;

endpackage

/* File: src/fdr_diag_mux.sv */
/*
  Builds the diagnostic input byte and the mask of bits that are driven,
  for the compatibility mode in force. Purely combinational.
*/
`timescale 1ns/10ps
module fdr_diag_mux (
  input wire fdr_pkg::fdr_mode_t i_mode,
  input wire logic i_disk_change_n,
  input wire logic i_dma_gate_enable,
  input wire logic i_precomp_disable,
  input wire logic [1:0] i_rate_sel,
  output logic [7:0] o_diag,
  output logic [7:0] o_diag_oe
);
  import fdr_pkg::*;

  // low rates report high_density_n high
  function automatic logic high_density_n(input logic [1:0] rate);
    high_density_n = (rate == FDR_RATE_250K) || (rate == FDR_RATE_300K);
  endfunction

  always_comb begin
    unique case (i_mode)
      FDR_SECOND_COMPAT_MODE: begin
        o_diag = {~i_disk_change_n, FDR_SECOND_ONES, i_rate_sel,
                  high_density_n(i_rate_sel)};
        o_diag_oe = FDR_OE_ALL;
      end
      FDR_THIRD_COMPAT_MODE: begin
        o_diag = {i_disk_change_n, 3'h0, i_dma_gate_enable, i_precomp_disable,
                  i_rate_sel};
        o_diag_oe = FDR_OE_ALL;
      end
      default: begin
        // basic mode, and the unused mode code: only the change bit is driven
        o_diag = {~i_disk_change_n, 7'h00};
        o_diag_oe = FDR_OE_BASIC;
      end
    endcase
  end

endmodule

/* File: src/fdr_status_pack.sv */
/*
  Packs the drive's status lines into the drive-status result byte.
  Assumes the lines are synchronous to the controller clock.
*/
`timescale 1ns/10ps
module fdr_status_pack (
  input wire fdr_pkg::fdr_drv_stat_t i_stat,
  output logic [7:0] o_status
);
  import fdr_pkg::*;

  always_comb begin
    o_status = {i_stat.drive_fault, i_stat.write_protect, i_stat.drive_ready,
                i_stat.track_zero, i_stat.two_sided, i_stat.head_address,
                i_stat.unit_select_hi, i_stat.unit_select_lo};
  end

endmodule

/* File: src/fdr_rate_port.sv */
/*
  Drive-input diagnostic port and rate-control port of a floppy controller,
  reached over APB, plus the shared data-rate register write and the drive-status
  result byte. Assumes the mode, disk-change, DMA-gate and drive-status inputs are
  synchronous to i_clk and stable while an access is in its setup cycle.

*/
`timescale 1ns/10ps
module fdr_rate_port (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire fdr_pkg::fdr_apb_req_t i_apb,
  output fdr_pkg::fdr_apb_rsp_t o_apb,
  input wire fdr_pkg::fdr_mode_t i_mode,
  input wire logic i_disk_change_n,
  input wire logic i_dma_gate_enable,
  input wire fdr_pkg::fdr_drv_stat_t i_drv_stat,
  output logic [1:0] o_rate_sel,
  output logic o_precomp_disable,
  output logic [7:0] o_diag_oe
);
  import fdr_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [1:0] rate_sel;
    logic precomp_disable;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] diag_oe;
  } fdr_state_t;

  fdr_state_t state_r;
  fdr_state_t state_nxt;

  logic [7:0] diag_byte;
  logic [7:0] diag_mask;
  logic [7:0] status_byte;
  logic setup_ph;
  logic access_ph;
  logic [5:0] reg_idx;
  logic addr_aligned;
  logic hit_rate;
  logic hit_diag;
  logic hit_status;

  // ==========================================================================
  // decode
  // ==========================================================================
  function automatic logic idx_is(input logic [FDR_ADDR_W-1:0] addr,
                                  input logic [5:0] idx);
    idx_is = (addr[1:0] == 2'h0) && (addr[FDR_ADDR_W-1:2] == idx);
  endfunction

  assign setup_ph = i_apb.psel && !i_apb.penable;
  assign access_ph = i_apb.psel && i_apb.penable;
  assign reg_idx = i_apb.paddr[FDR_ADDR_W-1:2];
  assign addr_aligned = (i_apb.paddr[1:0] == 2'h0);
  assign hit_rate = idx_is(i_apb.paddr, FDR_IDX_DATA_RATE);
  assign hit_diag = idx_is(i_apb.paddr, FDR_IDX_DIAG_RATE);
  assign hit_status = idx_is(i_apb.paddr, FDR_IDX_DRV_STATUS);

  // ==========================================================================
  // submodules
  // ==========================================================================
  fdr_diag_mux u_diag (
    .i_mode(i_mode),
    .i_disk_change_n(i_disk_change_n),
    .i_dma_gate_enable(i_dma_gate_enable),
    .i_precomp_disable(state_r.precomp_disable),
    .i_rate_sel(state_r.rate_sel),
    .o_diag(diag_byte),
    .o_diag_oe(diag_mask)
  );

  fdr_status_pack u_status (
    .i_stat(i_drv_stat),
    .o_status(status_byte)
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    // read data and error are prepared in the setup cycle
    if (setup_ph) begin
      state_nxt.prdata = 32'h0000_0000;
      state_nxt.pslverr = 1'b0;
      state_nxt.diag_oe = FDR_OE_ALL;
      if (!i_apb.pwrite) begin
        if (hit_diag) begin
          state_nxt.prdata = {24'h00_0000, diag_byte};
          state_nxt.diag_oe = diag_mask;
        end else if (hit_status) begin
          state_nxt.prdata = {24'h00_0000, status_byte};
        end else begin
          // data-rate register is write-only; any other index is unmapped
          state_nxt.pslverr = 1'b1;
        end
      end else begin
        state_nxt.pslverr = !(hit_diag || hit_rate);
      end
    end
    // writes take effect at the completing edge of the access phase
    if (access_ph && i_apb.pwrite) begin
      if (hit_diag) begin
        state_nxt.rate_sel = i_apb.pwdata[FDR_RATE_LSB +: 2];
        if (i_mode == FDR_THIRD_COMPAT_MODE) begin
          state_nxt.precomp_disable = i_apb.pwdata[FDR_PREC_WR_BIT];
        end
      end else if (hit_rate) begin
        state_nxt.rate_sel = i_apb.pwdata[FDR_RATE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r.rate_sel <= FDR_RATE_RST;
      state_r.precomp_disable <= FDR_PREC_RST;
      state_r.prdata <= 32'h0000_0000;
      state_r.pslverr <= 1'b0;
      state_r.diag_oe <= FDR_OE_ALL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // one wait-free access phase: ready whenever the slave is in access
  assign o_apb.pready = access_ph;
  assign o_apb.pslverr = state_r.pslverr && access_ph;
  assign o_apb.prdata = state_r.prdata;
  assign o_rate_sel = state_r.rate_sel;
  assign o_precomp_disable = state_r.precomp_disable;
  assign o_diag_oe = state_r.diag_oe;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic rd_diag_setup;
  logic rd_stat_setup;
  logic wr_diag_acc;
  logic wr_rate_acc;
  assign rd_diag_setup = setup_ph && !i_apb.pwrite && hit_diag;
  assign rd_stat_setup = setup_ph && !i_apb.pwrite && hit_status;
  assign wr_diag_acc = access_ph && i_apb.pwrite && hit_diag;
  assign wr_rate_acc = access_ph && i_apb.pwrite && hit_rate;

  AST_DIAG_UPPER_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_diag_setup |=> (o_apb.prdata[31:8] == 24'h00_0000) && !o_apb.pslverr
  ) else $error("diag read returned upper bits or an error");

  AST_DIAG_RO: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (access_ph && i_apb.pwrite && hit_diag) |=> $stable(state_r.prdata)
  ) else $error("write to diag index disturbed read data");

  AST_BASIC_LAYOUT: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_BASIC_COMPAT_MODE) |=>
      (o_apb.prdata[7] == !$past(i_disk_change_n)) &&
      (o_apb.prdata[6:0] == 7'h00) && (o_diag_oe == FDR_OE_BASIC)
  ) else $error("basic mode diag layout wrong");

  AST_SECOND_CHG: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_SECOND_COMPAT_MODE) |=>
      o_apb.prdata[FDR_DIAG_CHG_BIT] == !$past(i_disk_change_n)
  ) else $error("second mode change bit not inverted");

  AST_SECOND_ONES: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_SECOND_COMPAT_MODE) |=>
      (o_apb.prdata[6:3] == FDR_SECOND_ONES) && (o_diag_oe == FDR_OE_ALL)
  ) else $error("second mode bits 6-3 not ones");

  AST_SECOND_DENS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_SECOND_COMPAT_MODE) |=>
      o_apb.prdata[0] == ($past(o_rate_sel) == FDR_RATE_250K ||
                          $past(o_rate_sel) == FDR_RATE_300K)
  ) else $error("second mode density bit wrong");

  AST_THIRD_CHG: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[FDR_DIAG_CHG_BIT] == $past(i_disk_change_n)
  ) else $error("third mode change bit not raw");

  AST_THIRD_ZEROS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[6:4] == 3'h0
  ) else $error("third mode bits 6-4 not zero");

  AST_THIRD_DMA: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[FDR_DIAG_DMA_BIT] == $past(i_dma_gate_enable)
  ) else $error("third mode dma gate bit wrong");

  AST_THIRD_PREC: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[FDR_DIAG_PREC_BIT] == $past(o_precomp_disable)
  ) else $error("third mode precomp bit wrong");

  AST_THIRD_RATE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[1:0] == $past(o_rate_sel)
  ) else $error("third mode rate bits wrong");

  AST_CC_RATE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_diag_acc |=> o_rate_sel == $past(i_apb.pwdata[1:0])
  ) else $error("rate control write did not set rate");

  AST_RATE_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_diag_acc || wr_rate_acc) |=> $stable(o_rate_sel)
  ) else $error("rate changed without a write");

  AST_PREC_SET: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (wr_diag_acc && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_precomp_disable == $past(i_apb.pwdata[FDR_PREC_WR_BIT])
  ) else $error("precomp disable not taken in third mode");

  AST_PREC_KEEP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_diag_acc && i_mode == FDR_THIRD_COMPAT_MODE) |=> $stable(o_precomp_disable)
  ) else $error("precomp disable changed outside third mode write");

  AST_STATUS_BYTE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_stat_setup |=>
      o_apb.prdata[7:0] == {$past(i_drv_stat.drive_fault), $past(i_drv_stat.write_protect),
                            $past(i_drv_stat.drive_ready), $past(i_drv_stat.track_zero),
                            $past(i_drv_stat.two_sided), $past(i_drv_stat.head_address),
                            $past(i_drv_stat.unit_select_hi),
                            $past(i_drv_stat.unit_select_lo)}
  ) else $error("drive status byte layout wrong");

  AST_SHARED_RATE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_rate_acc ##2 (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_apb.prdata[1:0] == $past(i_apb.pwdata[1:0], 3)
  ) else $error("data-rate write not seen through diag port");

  AST_READY_ACCESS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    setup_ph |=> (access_ph |-> o_apb.pready)
  ) else $error("access phase without ready");

  AST_UNMAPPED_ERR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && !hit_diag && !hit_rate && !hit_status) ##1 access_ph |->
      o_apb.pslverr
  ) else $error("unmapped access completed without error");

  AST_RATE_PORT_WR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_rate_acc |=> o_rate_sel == $past(i_apb.pwdata[1:0])
  ) else $error("data-rate write did not set rate");

  AST_SECOND_RATE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_SECOND_COMPAT_MODE) |=>
      o_apb.prdata[2:1] == $past(o_rate_sel)
  ) else $error("second mode rate bits wrong");

  AST_CODE3_BASIC: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == fdr_mode_t'(2'h3)) |=>
      (o_apb.prdata[6:0] == 7'h00) && (o_diag_oe == FDR_OE_BASIC)
  ) else $error("unused mode code not read as basic layout");

  AST_DIAG_OE_THIRD: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_diag_setup && i_mode == FDR_THIRD_COMPAT_MODE) |=>
      o_diag_oe == FDR_OE_ALL
  ) else $error("third mode diag bits not all driven");

  AST_OE_OTHER: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && !rd_diag_setup) |=> o_diag_oe == FDR_OE_ALL
  ) else $error("driven mask not full after other access");

  AST_PRDATA_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !setup_ph |=> $stable(o_apb.prdata)
  ) else $error("read data changed outside a setup cycle");

  AST_DR_READ_ERR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && !i_apb.pwrite && hit_rate) ##1 access_ph |-> o_apb.pslverr
  ) else $error("read of write-only data-rate index not refused");

  AST_STATUS_WR_ERR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && i_apb.pwrite && hit_status) ##1 access_ph |-> o_apb.pslverr
  ) else $error("write of read-only status index not refused");

  AST_MISALIGNED_ERR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && !addr_aligned) ##1 access_ph |-> o_apb.pslverr
  ) else $error("misaligned access not refused");

  AST_HIGH_IDX_ERR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && reg_idx > FDR_IDX_DRV_STATUS) ##1 access_ph |-> o_apb.pslverr
  ) else $error("access above the last index not refused");

  AST_MAPPED_OK: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && (hit_diag || (i_apb.pwrite ? hit_rate : hit_status))) ##1 access_ph |->
      !o_apb.pslverr && o_apb.pready
  ) else $error("mapped access refused");

  AST_REFUSED_WR_KEEP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (setup_ph && i_apb.pwrite && !hit_diag && !hit_rate) ##1 access_ph |=>
      $stable(o_rate_sel)
  ) else $error("refused write changed the rate");

endmodule

/* File: tb/fdr_drive_model.sv */
/*
  Behavioural floppy drive for the rate-port bench: disk-change pin and status lines.
  Assumes the bench sets the media-change state and status pattern between accesses.
*/
`timescale 1ns/10ps
module fdr_drive_model (
  input wire logic i_media_changed,
  input wire logic [7:0] i_stat_pat,
  output logic o_disk_change_n,
  output fdr_pkg::fdr_drv_stat_t o_drv_stat
);
  import fdr_pkg::*;
  // ==========================================================================
  // drive pins
  // ==========================================================================
  // change pin is active low while the media-changed latch is set
  assign o_disk_change_n = ~i_media_changed;
  // pattern bit 7 is the fault line down to bit 0, unit select low
  assign o_drv_stat = fdr_drv_stat_t'(i_stat_pat);
endmodule

/* File: tb/fdr_rate_port_bench.sv */
/*
  Self-checking bench for the drive-input diagnostic and rate-control ports.
  Assumes the zero-wait APB slave and register indexes of the design package.
*/
`timescale 1ns/10ps
module fdr_rate_port_bench;
  import fdr_pkg::*;
  logic i_clk;
  logic i_reset_n;
  fdr_apb_req_t apb;
  fdr_apb_rsp_t rsp;
  fdr_mode_t mode;
  logic chg;
  logic dma;
  logic [7:0] stat_pat;
  logic disk_change_n;
  fdr_drv_stat_t drv_stat;
  logic [1:0] rate_sel;
  logic prec;
  logic [7:0] diag_oe;
  int error_cnt;
  int checks_done;
  int cycles;
  logic [31:0] rd;
  logic err;
  logic cur_prec;
  logic [7:0] wdat;
  logic [15:0] ed;
  logic [7:0] pats [4] = '{8'hA5, 8'h5A, 8'h80, 8'h01};

  fdr_rate_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(apb), .o_apb(rsp),
    .i_mode(mode), .i_disk_change_n(disk_change_n), .i_dma_gate_enable(dma),
    .i_drv_stat(drv_stat), .o_rate_sel(rate_sel), .o_precomp_disable(prec),
    .o_diag_oe(diag_oe));
  fdr_drive_model drive (.i_media_changed(chg), .i_stat_pat(stat_pat),
    .o_disk_change_n(disk_change_n), .o_drv_stat(drv_stat));

  // ==========================================================================
  // clock, reset and timeout
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("mismatch timeout expected done seen hang");
      finish_test();
    end
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one APB transfer: setup cycle, access until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    chk("wait cycles", 32'h1, n);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic e);
    xfer(1'b1, a, {24'h0, d});
    chk("write error", {31'h0, e}, {31'h0, err});
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m,
                        input logic e);
    xfer(1'b0, a, 32'h0);
    chk("read error", {31'h0, e}, {31'h0, err});
    if (e == 1'b0) begin
      chk("read data", {24'h0, x & m}, rd & {24'h0, m});
    end
  endtask

  function automatic logic [15:0] exp_diag(input fdr_mode_t m, input logic n,
                                           input logic e, input logic p,
                                           input logic [1:0] r);
    case (m)
      FDR_SECOND_COMPAT_MODE: exp_diag = {~n, 4'hF, r,
                                          r == FDR_RATE_250K || r == FDR_RATE_300K, 8'hFF};
      FDR_THIRD_COMPAT_MODE: exp_diag = {n, 3'h0, e, p, r, 8'hFF};
      default: exp_diag = {~n, 7'h0, 8'h80};
    endcase
  endfunction

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    apb = '0;
    mode = FDR_BASIC_COMPAT_MODE;
    chg = 1'b0;
    dma = 1'b0;
    stat_pat = 8'h00;
    i_reset_n = 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk("rate reset", {30'h0, FDR_RATE_RST}, {30'h0, rate_sel});
    chk("precomp reset", {31'h0, FDR_PREC_RST}, {31'h0, prec});
    chk("oe reset", 32'hFF, {24'h0, diag_oe});
    cur_prec = FDR_PREC_RST;
    @(posedge i_clk);
    // every mode code with every rate code, change pin and DMA gate
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 4; r++) begin
        mode <= fdr_mode_t'(m[1:0]);
        chg <= r[0];
        dma <= r[1];
        wdat = {6'h0, r[1:0]};
        if (m == 2) begin
          wdat[2] = r[0] ^ r[1];
          cur_prec = r[0] ^ r[1];
        end
        wr_reg(8'h1C, wdat, 1'b0);
        @(negedge i_clk);
        chk("rate sel", r, {30'h0, rate_sel});
        chk("precomp", {31'h0, cur_prec}, {31'h0, prec});
        ed = exp_diag(fdr_mode_t'(m[1:0]), ~r[0], r[1], cur_prec, r[1:0]);
        rd_reg(8'h1C, ed[15:8], ed[7:0], 1'b0);
        chk("diag oe", (m == 0 || m == 3) ? 32'h80 : 32'hFF, {24'h0, diag_oe});
      end
    end
    // shared rate selection between the two write ports
    mode <= FDR_THIRD_COMPAT_MODE;
    wr_reg(8'h10, 8'h01, 1'b0);
    rd_reg(8'h1C, {4'h0, dma, cur_prec, 2'h1}, 8'h0F, 1'b0);
    wr_reg(8'h1C, 8'h03, 1'b0);
    wr_reg(8'h10, 8'h00, 1'b0);
    @(negedge i_clk);
    chk("shared rate", 32'h0, {30'h0, rate_sel});
    // refused accesses leave the rate alone
    rd_reg(8'h10, 8'h00, 8'h00, 1'b1);
    wr_reg(8'h20, 8'h03, 1'b1);
    rd_reg(8'h40, 8'h00, 8'h00, 1'b1);
    wr_reg(8'h1D, 8'h03, 1'b1);
    @(negedge i_clk);
    chk("rate kept", 32'h0, {30'h0, rate_sel});
    // reset in mid-run brings the shared rate back to its reset code
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk("rate after reset", {30'h0, FDR_RATE_RST}, {30'h0, rate_sel});
    @(posedge i_clk);
    // drive-status byte layout
    for (int i = 0; i < 4; i++) begin
      stat_pat <= pats[i];
      rd_reg(8'h20, pats[i], 8'hFF, 1'b0);
    end
    finish_test();
  end
endmodule
